// ---- tcs_step_ctrl.sv ----
`timescale 1ns/1ps
`include "tcs_map.svh"
// Function
// - inductor min with cap max and series bank off home advances series bank.
// - series bank away from home asserts inductor force inhibit.
// - series switch at position 21 (75pf) asserts inductor home command.
// - tuning-cycle start sets the shunt bank homing latch.
// - tuning-cycle start sets series bank homing latch, running its motor home.
// - any shunt capacitance position 100pf to 1200pf clears shunt advance latch.
// - shunt homing latch set keeps the shunt motor relay energized.
// - shunt switch at position 16 keeps the shunt motor running.
// - shunt position 16 advances series bank unless shunt bank is homing.
// - inductor min, zero phase error and above 50 ohms advance series bank.
// - series home switch clears the series bank homing latch.
// - shunt home switch clears the shunt bank homing latch.
// - each inductor-maximum pulse sets the shunt bank advance latch.
// - series motor starting forces the shunt bank home.
////////////////////////////////////////////////////////////////////////////////
module tcs_step_ctrl #(
  parameter int ADDR_W = `TCS_ADDR_W,
  parameter int DBNC_CYCLES = `TCS_DBNC_US * `TCS_CLK_MHZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire tcs_pkg::tcs_pins_t pins,
  output tcs_pkg::tcs_drive_t drive
);
  import tcs_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic have_aw;
    logic have_w;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic en;
    logic sw_start;
    logic [`TCS_CNT_W-1:0] dbnc_limit;
    logic prev_ind_max;
    logic prev_pos_any;
    tcs_drive_t drive;
  } tcs_main_t;

  tcs_main_t st;
  tcs_main_t next_st;
  tcs_pins_t deb;
  tcs_latch_t lat;
  logic start;
  logic max_pulse;
  logic pos_arrive;
  logic run_series;
  logic run_shunt;
  logic series_start;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode and byte-lane merge
  function automatic tcs_reg_t reg_sel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'b00};
    if (w == ADDR_W'(`TCS_OFF_CTRL)) begin
      reg_sel = TCS_REG_CTRL;
    end else if (w == ADDR_W'(`TCS_OFF_STATUS)) begin
      reg_sel = TCS_REG_STATUS;
    end else if (w == ADDR_W'(`TCS_OFF_DBNC)) begin
      reg_sel = TCS_REG_DBNC;
    end else begin
      reg_sel = TCS_REG_NONE;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // input conditioning
  tcs_debounce #(
    .W($bits(tcs_pins_t)),
    .CW(`TCS_CNT_W)
  ) u_debounce (
    .aclk(aclk),
    .aresetn(aresetn),
    .limit(st.dbnc_limit),
    .din(pins),
    .dout(deb)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // homing and advance latches
  assign start = deb.tune_start | st.sw_start;
  assign max_pulse = deb.ind_max & ~st.prev_ind_max;
  // arrival on a shunt contact; the old contact still shows while the motor leaves it
  assign pos_arrive = (deb.shunt_cap | deb.shunt_pos16 | deb.shunt_home) & ~st.prev_pos_any;

  // series bank motor: homing or any of the three advance conditions
  assign run_series = st.en & (lat.series_home
                      | (deb.ind_min_cap_max & ~deb.series_home)
                      | (deb.shunt_pos16 & ~lat.shunt_home)
                      | deb.ind_min_match);
  // shunt bank motor: homing, advancing, or passing position 16
  assign run_shunt = st.en & (lat.shunt_home
                     | lat.shunt_adv
                     | deb.shunt_pos16);
  assign series_start = run_series & ~st.drive.series_motor_relay;

  tcs_bistable_latch u_shunt_home (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(start | series_start),
    .clr(deb.shunt_home),
    .q(lat.shunt_home)
  );

  tcs_bistable_latch u_series_home (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(start),
    .clr(deb.series_home),
    .q(lat.series_home)
  );

  tcs_bistable_latch u_shunt_adv (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(max_pulse),
    .clr(pos_arrive),
    .q(lat.shunt_adv)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave and output drives
  always_comb begin
    next_st = st;
    next_st.sw_start = 1'b0;
    next_st.prev_ind_max = deb.ind_max;
    next_st.prev_pos_any = deb.shunt_cap | deb.shunt_pos16 | deb.shunt_home;
    next_st.drive.shunt_motor_relay = run_shunt;
    next_st.drive.series_motor_relay = run_series;
    next_st.drive.inductor_home_cmd = deb.series_pos21;
    next_st.drive.inductor_force_inhibit = ~deb.series_home;
    if (st.awready && awvalid) begin
      next_st.have_aw = 1'b1;
      next_st.waddr = awaddr;
    end
    if (st.wready && wvalid) begin
      next_st.have_w = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.have_aw && st.have_w && !st.bvalid) begin
      next_st.have_aw = 1'b0;
      next_st.have_w = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `TCS_RESP_OKAY;
      unique case (reg_sel(st.waddr))
        TCS_REG_CTRL: begin
          if (st.wstrb[0]) begin
            next_st.en = st.wdata[`TCS_CTRL_EN];
            next_st.sw_start = st.wdata[`TCS_CTRL_START];
          end
        end
        TCS_REG_DBNC: begin
          next_st.dbnc_limit = `TCS_CNT_W'(merge(32'(st.dbnc_limit), st.wdata,
                                                 st.wstrb));
        end
        TCS_REG_STATUS: begin
          next_st.bresp = `TCS_RESP_OKAY;
        end
        TCS_REG_NONE: begin
          next_st.bresp = `TCS_RESP_DECERR;
        end
      endcase
    end
    next_st.awready = !next_st.have_aw && !next_st.bvalid;
    next_st.wready = !next_st.have_w && !next_st.bvalid;
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (st.arready && arvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = '0;
      next_st.rresp = `TCS_RESP_OKAY;
      unique case (reg_sel(araddr))
        TCS_REG_CTRL: begin
          next_st.rdata[`TCS_CTRL_EN] = st.en;
        end
        TCS_REG_STATUS: begin
          next_st.rdata[`TCS_ST_DRIVE +: $bits(tcs_drive_t)] = st.drive;
          next_st.rdata[`TCS_ST_LATCH +: $bits(tcs_latch_t)] = lat;
          next_st.rdata[`TCS_ST_PINS +: $bits(tcs_pins_t)] = deb;
        end
        TCS_REG_DBNC: begin
          next_st.rdata[`TCS_CNT_W-1:0] = st.dbnc_limit;
        end
        TCS_REG_NONE: begin
          next_st.rresp = `TCS_RESP_DECERR;
        end
      endcase
    end
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.en <= `TCS_CTRL_EN_RST;
      st.dbnc_limit <= `TCS_CNT_W'(DBNC_CYCLES);
    end else begin
      st <= next_st;
    end
  end

  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign drive = st.drive;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_lmin_cmax_adv: assert property (
    st.en && deb.ind_min_cap_max && !deb.series_home |=> drive.series_motor_relay)
    else $error("series bank not advanced on lmin cmax");
  a_force_inhibit: assert property (
    !deb.series_home |=> drive.inductor_force_inhibit ##0 !$stable(deb.series_home)
    or drive.inductor_force_inhibit)
    else $error("force inhibit missing while series bank off home");
  a_home_cmd: assert property (
    deb.series_pos21 |=> drive.inductor_home_cmd)
    else $error("inductor home command missing at series 75pf step");
  a_start_shunt: assert property (
    start |=> lat.shunt_home)
    else $error("shunt homing latch not set on start");
  a_start_series: assert property (
    start |=> lat.series_home ##1 (!st.en || drive.series_motor_relay))
    else $error("series bank not homing after start");
  a_cap_pos_clr: assert property (
    pos_arrive && !max_pulse |=> !lat.shunt_adv)
    else $error("shunt advance latch not cleared at a cap position");
  a_shunt_homing: assert property (
    lat.shunt_home && st.en |=> drive.shunt_motor_relay)
    else $error("shunt relay off while shunt bank homing");
  a_pos16_run: assert property (
    deb.shunt_pos16 && st.en |=> drive.shunt_motor_relay)
    else $error("shunt relay dropped at position 16");
  a_pos16_advance: assert property (
    deb.shunt_pos16 && !lat.shunt_home && st.en |=> drive.series_motor_relay)
    else $error("series bank not advanced at shunt position 16");
  a_pos16_suppress: assert property (
    lat.shunt_home && !lat.series_home && !deb.ind_min_match
    && !(deb.ind_min_cap_max && !deb.series_home) |=> !drive.series_motor_relay)
    else $error("series bank advanced while shunt bank homing");
  a_match_adv: assert property (
    deb.ind_min_match && st.en |=> drive.series_motor_relay)
    else $error("series bank not advanced on lmin zero phase");
  a_series_home_clr: assert property (
    deb.series_home && !start |=> !lat.series_home)
    else $error("series homing latch not cleared at home");
  a_shunt_home_clr: assert property (
    deb.shunt_home && !start && !series_start |=> !lat.shunt_home)
    else $error("shunt homing latch not cleared at home");
  a_max_sets_adv: assert property (
    max_pulse |=> lat.shunt_adv)
    else $error("shunt advance latch not set on inductor max");
  a_series_start: assert property (
    $rose(drive.series_motor_relay) |-> lat.shunt_home)
    else $error("shunt bank not forced home on series step");
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> drive.shunt_motor_relay == 1'b0 && drive.series_motor_relay == 1'b0)
    else $error("motor relay energized after reset");
endmodule

// ---- tcs_map.svh ----
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH

// bus geometry
`define TCS_ADDR_W 8
`define TCS_OFF_CTRL 8'h00
`define TCS_OFF_STATUS 8'h04
`define TCS_OFF_DBNC 8'h08

// control word fields
`define TCS_CTRL_EN 0
`define TCS_CTRL_START 1
`define TCS_CTRL_EN_RST 1'b1

// status word fields
`define TCS_ST_DRIVE 0
`define TCS_ST_LATCH 4
`define TCS_ST_PINS 8

// responses
`define TCS_RESP_OKAY 2'h0
`define TCS_RESP_DECERR 2'h3

// timing: debounce time in microseconds (1000 us) and clock rate in MHz
`define TCS_DBNC_US 32'h000003E8
`define TCS_CLK_MHZ 32'h0000000A
`define TCS_CNT_W 16

`endif

// ---- tcs_pkg.sv ----
package tcs_pkg;

  // condition inputs, active high after synchronising
  typedef struct packed {
    logic tune_start;
    logic series_home;
    logic series_pos21;
    logic shunt_home;
    logic shunt_cap;
    logic shunt_pos16;
    logic ind_max;
    logic ind_min_cap_max;
    logic ind_min_match;
  } tcs_pins_t;

  // relay and line drives
  typedef struct packed {
    logic shunt_motor_relay;
    logic series_motor_relay;
    logic inductor_home_cmd;
    logic inductor_force_inhibit;
  } tcs_drive_t;

  // bistable_latch states
  typedef struct packed {
    logic shunt_home;
    logic series_home;
    logic shunt_adv;
  } tcs_latch_t;

  typedef enum logic [1:0] {
    TCS_REG_CTRL,
    TCS_REG_STATUS,
    TCS_REG_DBNC,
    TCS_REG_NONE
  } tcs_reg_t;

endpackage

// ---- tcs_bistable_latch.sv ----
`timescale 1ns/1ps
module tcs_bistable_latch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  import tcs_pkg::*;

  typedef struct packed {
    logic q;
  } tcs_bl_t;

  tcs_bl_t st;
  tcs_bl_t next_st;

  // set wins over clear
  always_comb begin
    next_st = st;
    if (set) begin
      next_st.q = 1'b1;
    end else if (clr) begin
      next_st.q = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;

  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn) set |=> q)
    else $error("latch missed a set");
  a_reset_clear: assert property (@(posedge aclk) !aresetn |=> !q)
    else $error("latch not clear after reset");
endmodule

// ---- tcs_debounce.sv ----
`timescale 1ns/1ps
`include "tcs_map.svh"
module tcs_debounce #(
  parameter int W = 9,
  parameter int CW = `TCS_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CW-1:0] limit,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  import tcs_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] stable;
    logic [W-1:0][CW-1:0] cnt;
  } tcs_deb_t;

  tcs_deb_t st;
  tcs_deb_t next_st;

  // two-stage sync, then a level must hold limit+1 cycles to be taken
  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.stable[i]) begin
        next_st.cnt[i] = '0;
      end else if (st.cnt[i] >= limit) begin
        next_st.stable[i] = st.s2[i];
        next_st.cnt[i] = '0;
      end else begin
        next_st.cnt[i] = CW'(st.cnt[i] + 1'b1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.stable;

  a_deb_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(st.stable) |-> ((st.stable ^ $past(st.s2)) & ($past(st.stable) ^ st.stable)) == '0)
    else $error("debounced level not taken from synchroniser");
endmodule

// ---- tcs_motor_model.sv ----
`timescale 1ns/1ps
// stepping motors and wafer switches behind the two motor relays
module tcs_motor_model #(
  parameter int MOVE_T = 40,
  parameter int SER_LAST = 3,
  parameter int SER_P75 = 2
) (
  input wire logic aclk,
  input wire tcs_pkg::tcs_drive_t drive,
  output logic series_home,
  output logic series_pos21,
  output logic shunt_home,
  output logic shunt_cap,
  output logic shunt_pos16
);
  // shunt wafer: 0 home, 1..5 capacitance steps, 6 position 16
  int shunt_idx = 0;
  int ser_idx = 0;
  int shunt_t = 0;
  int ser_t = 0;
  // shunt wiper leaves its contact halfway through a step
  localparam int CONTACT_T = MOVE_T / 2;
  // a motor moves one step after MOVE_T+1 cycles of continuous drive
  always @(posedge aclk) begin
    if (drive.shunt_motor_relay !== 1'b1) begin
      shunt_t <= 0;
    end else if (shunt_t == MOVE_T) begin
      shunt_t <= 0;
      shunt_idx <= (shunt_idx == 6) ? 0 : shunt_idx + 1;
    end else begin
      shunt_t <= shunt_t + 1;
    end
    if (drive.series_motor_relay !== 1'b1) begin
      ser_t <= 0;
    end else if (ser_t == MOVE_T) begin
      ser_t <= 0;
      ser_idx <= (ser_idx == SER_LAST) ? 0 : ser_idx + 1;
    end else begin
      ser_t <= ser_t + 1;
    end
  end
  assign shunt_home = (shunt_idx == 0) && (shunt_t < CONTACT_T);
  assign shunt_cap = (shunt_idx >= 1) && (shunt_idx <= 5) && (shunt_t < CONTACT_T);
  assign shunt_pos16 = (shunt_idx == 6) && (shunt_t < CONTACT_T);
  assign series_home = (ser_idx == 0);
  assign series_pos21 = (ser_idx == SER_P75);
endmodule

// ---- tb_tuning_capacitor_step_control.sv ----
`timescale 1ns/1ps
module tb_tuning_capacitor_step_control;
  import tcs_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata, st;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic tune_start = 0, ind_max = 0, ind_min_cap_max = 0, ind_min_match = 0;
  logic series_home, series_pos21, shunt_home, shunt_cap, shunt_pos16;
  logic saw_shunt = 0, saw_series = 0;
  tcs_pins_t pins;
  tcs_drive_t drive;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  always #50 aclk = ~aclk;
  assign pins = {tune_start, series_home, series_pos21, shunt_home, shunt_cap,
    shunt_pos16, ind_max, ind_min_cap_max, ind_min_match};
  tcs_step_ctrl #(.DBNC_CYCLES(2)) DUT (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .pins(pins),
    .drive(drive));
  tcs_motor_model u_motor (.aclk(aclk), .drive(drive), .series_home(series_home),
    .series_pos21(series_pos21), .shunt_home(shunt_home), .shunt_cap(shunt_cap),
    .shunt_pos16(shunt_pos16));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    bready <= 0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (drive.shunt_motor_relay === 1'b1) saw_shunt <= 1;
    if (drive.series_motor_relay === 1'b1) saw_series <= 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    repeat (30) @(posedge aclk);
    axi_rd(8'h00, 2'h0, st);
    chk("ctrl", 32'h00000001, st);
    axi_rd(8'h08, 2'h0, st);
    chk("dbnc", 32'h00000002, st);
    axi_rd(8'h0C, 2'h3, st);
    axi_wr(8'h10, 32'h00000000, 2'h3);
    axi_wr(8'h04, 32'hFFFFFFFF, 2'h0);
    axi_rd(8'h04, 2'h0, st);
    chk("status idle", 32'h0000A000, st);
    // series advance on the match condition, shunt forced home on series start
    saw_shunt = 0;
    saw_series = 0;
    ind_min_match <= 1;
    for (int i = 0; i < 200 && drive.inductor_force_inhibit !== 1'b1; i++) @(posedge aclk);
    ind_min_match <= 0;
    repeat (20) @(posedge aclk);
    chk("series relay", 32'h1, {31'h0, saw_series});
    chk("shunt forced", 32'h1, {31'h0, saw_shunt});
    chk("force inhibit", 32'h1, {31'h0, drive.inductor_force_inhibit});
    // lmin-cmax with series off home steps up to the 75pf position
    ind_min_cap_max <= 1;
    for (int i = 0; i < 300 && drive.inductor_home_cmd !== 1'b1; i++) @(posedge aclk);
    chk("home cmd", 32'h1, {31'h0, drive.inductor_home_cmd});
    chk("series step", 32'h1, {31'h0, drive.series_motor_relay});
    ind_min_cap_max <= 0;
    repeat (20) @(posedge aclk);
    chk("series stop", 32'h0, {31'h0, drive.series_motor_relay});
    // tuning start homes both banks
    saw_shunt = 0;
    tune_start <= 1;
    repeat (10) @(posedge aclk);
    tune_start <= 0;
    axi_rd(8'h04, 2'h0, st);
    chk("series latch", 32'h1, {31'h0, st[5]});
    chk("series run", 32'h1, {31'h0, st[2]});
    chk("shunt latch run", 32'h1, {31'h0, saw_shunt});
    for (int i = 0; i < 400 && drive.inductor_force_inhibit !== 1'b0; i++) @(posedge aclk);
    repeat (10) @(posedge aclk);
    axi_rd(8'h04, 2'h0, st);
    chk("homed", 32'h0000A000, st);
    // each inductor max pulse inserts one shunt step
    for (int k = 1; k <= 5; k++) begin
      ind_max <= 1;
      repeat (12) @(posedge aclk);
      ind_max <= 0;
      repeat (80) @(posedge aclk);
      axi_rd(8'h04, 2'h0, st);
      chk("shunt step", 32'h00009000, st);
    end
    saw_series = 0;
    ind_max <= 1;
    repeat (12) @(posedge aclk);
    ind_max <= 0;
    for (int i = 0; i < 200 && shunt_pos16 !== 1'b1; i++) @(posedge aclk);
    repeat (12) @(posedge aclk);
    chk("pos16 run", 32'h1, {31'h0, drive.shunt_motor_relay});
    chk("pos16 series", 32'h1, {31'h0, saw_series});
    repeat (100) @(posedge aclk);
    chk("shunt back home", 32'h00000000, {28'h0, drive});
    // relays gated off by the enable bit
    axi_wr(8'h00, 32'h00000000, 2'h0);
    saw_series = 0;
    ind_min_match <= 1;
    repeat (20) @(posedge aclk);
    ind_min_match <= 0;
    repeat (20) @(posedge aclk);
    chk("en off", 32'h0, {31'h0, saw_series});
    axi_wr(8'h00, 32'h00000001, 2'h0);
    // a one-cycle glitch is filtered out
    saw_series = 0;
    ind_min_match <= 1;
    @(posedge aclk);
    ind_min_match <= 0;
    repeat (20) @(posedge aclk);
    chk("glitch", 32'h0, {31'h0, saw_series});
    // software start bit homes both banks
    saw_shunt = 0;
    saw_series = 0;
    axi_wr(8'h00, 32'h00000003, 2'h0);
    repeat (5) @(posedge aclk);
    chk("sw start shunt", 32'h1, {31'h0, saw_shunt});
    chk("sw start series", 32'h1, {31'h0, saw_series});
    // debounce limit write with only byte lane 0 strobed
    wstrb <= 4'h1;
    axi_wr(8'h08, 32'h0000AB07, 2'h0);
    wstrb <= 4'hF;
    axi_rd(8'h08, 2'h0, st);
    chk("dbnc lane", 32'h00000007, st);
    print_verdict();
  end
endmodule
